// File: rtl/hcb_pkg.sv
package hcb_pkg;

   // ***********************************************
   // clock and dead-time figures
   // ***********************************************
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned MIN_DT_NS     = 100;
   // least time, so round up to whole cycles
   localparam logic [7:0]  MIN_DT_CYC    =
      8'((MIN_DT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ***********************************************
   // register map (word aligned byte offsets)
   // ***********************************************
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_DEADTIME = 8'h04;
   localparam logic [7:0] REG_SLEW     = 8'h08;
   localparam logic [7:0] REG_STATUS   = 8'h0c;

   // control field positions
   localparam int unsigned CTRL_FW     = 0;
   localparam int unsigned CTRL_BRK_LO = 1;
   localparam int unsigned CTRL_OCP_EN = 3;
   localparam int unsigned CTRL_WDT_EN = 4;

   // values after reset
   localparam logic       RST_FW_ACTIVE = 1'b1;
   localparam logic [7:0] RST_DEADTIME_RISING   = 8'h0a;
   localparam logic [7:0] RST_DEADTIME_FALLING   = 8'h0a;
   localparam logic [7:0] RST_SLEW      = 8'h00;

   // ***********************************************
   // sequencer constants
   // ***********************************************
   localparam logic [2:0] HALL_ALL_LO   = 3'h0;
   localparam logic [2:0] HALL_ALL_HI   = 3'h7;
   localparam logic [2:0] STEPS_LAST    = 3'h5;
   localparam logic [3:0] STEPS_PER_HALF = 4'h6;

   typedef enum logic [1:0] {
      HCB_BRK_LOW  = 2'h0,
      HCB_BRK_HIGH = 2'h1,
      HCB_BRK_ALT  = 2'h2,
      HCB_BRK_HIZ  = 2'h3
   } hcb_brake_mode_t;

   typedef enum logic [1:0] {
      HCB_HALF_LS_ON = 2'b01,
      HCB_HALF_HS_ON = 2'b10
   } hcb_half_t;

endpackage

// File: rtl/hcb_deadtime.sv
`timescale 1ns/1ps
`default_nettype none

module hcb_deadtime
   import hcb_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   // requested gate levels
   input  wire logic       h_req,
   input  wire logic       l_req,
   // programmed dead times in cycles
   input  wire logic [7:0] deadtime_rising,
   input  wire logic [7:0] deadtime_falling,
   // gate drive
   output logic            high_gate,
   output logic            low_gate
);
   import hcb_pkg::*;

   typedef struct packed {
      logic       h;
      logic       l;
      logic [7:0] cnt;
   } hcb_dt_st_t;

   hcb_dt_st_t st_r;
   hcb_dt_st_t st_nxt;
   logic [7:0] eff_rise;
   logic [7:0] eff_fall;

   // the floor wins over a short programmed value
   assign eff_rise = (deadtime_rising < MIN_DT_CYC) ? MIN_DT_CYC : deadtime_rising;
   assign eff_fall = (deadtime_falling < MIN_DT_CYC) ? MIN_DT_CYC : deadtime_falling;

   // turn-off is immediate, turn-on waits for both gates off long enough
   always_comb
   begin
      st_nxt   = st_r;
      st_nxt.h = h_req & ~l_req & (st_r.h | (~st_r.l & (st_r.cnt >= eff_rise)));
      st_nxt.l = l_req & ~h_req & (st_r.l | (~st_r.h & (st_r.cnt >= eff_fall)));
      if (st_r.h | st_r.l)
         st_nxt.cnt = 8'h00;
      else if (st_r.cnt != 8'hff)
         st_nxt.cnt = st_r.cnt + 8'h01;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign high_gate = st_r.h;
   assign low_gate  = st_r.l;

   chk_no_overlap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !(st_r.h && st_r.l)) else $error("both gates of a phase on");

   chk_min_dead: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(st_r.l) |-> !st_r.h [*5]) else $error("high gate on inside minimum dead time");

   chk_rise_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(st_r.h) |-> ($past(st_r.cnt) >= $past(eff_rise)))
      else $error("high gate on before rising dead time");

endmodule
`default_nettype wire

// File: rtl/hcb_commutator.sv
// Decided for this implementation: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - alternate rotations: high-side modulation with low on, then low-side with high on.
// - twelve states, six per half, wrapping from last back to first.
// - freewheel select picks active or diode; diode holds complement outputs low.
// - dir 1, low side on: commutation table from Hall code.
// - dir 1, high side on: commutation table from Hall code.
// - dir 0, low side on: commutation table from Hall code.
// - dir 0, high side on: commutation table from Hall code.
// - Hall code 000 or 111 without brake drives all gates low.
// - brake pin low overrides commutation with the braking pattern.
// - overcurrent and watchdog faults start braking, each individually enabled.
// - low-side braking: all low gates on, all high gates off.
// - high-side braking: all high gates on, all low gates off.
// - alternating braking toggles side at each new braking event.
// - non-power braking turns all six gates off.
// - braking fields may be rewritten while running.
// - braking first turns conflicting gates off, waits dead time, then on.
// - dead time between high and low gate of each phase always.
// - rising dead time before rising node, falling before falling node.
// - a fixed minimum dead time is always enforced.
// - slew setting changes apply only at a PWM switching edge.
// - direction input selects direction 1 or direction 0 table.
// - the PWM input sets every modulated gate; with active freewheel the complement is its inverse.
// - the three Hall inputs form the code that selects the pattern.
module hcb_commutator
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // controller inputs
   input  wire logic        pwm_in,
   input  wire logic        direction_in,
   input  wire logic        brake_request_n,
   // hall sensors
   input  wire logic        hall_a_in,
   input  wire logic        hall_b_in,
   input  wire logic        hall_c_in,
   // fault sources
   input  wire logic        overcurrent_fault,
   input  wire logic        watchdog_fault,
   // gate drive
   output logic             high_gate_a,
   output logic             low_gate_a,
   output logic             high_gate_b,
   output logic             low_gate_b,
   output logic             high_gate_c,
   output logic             low_gate_c,
   // slew setting to the driver stage
   output logic [7:0]       slew_code
);
   import hcb_pkg::*;

   // ***********************************************
   // state
   // ***********************************************
   typedef struct packed {
      logic [2:0]      hall_s1;
      logic [2:0]      hall_s2;
      logic            brk_s1;
      logic            brk_s2;
      logic [2:0]      hall_last;
      hcb_half_t       half;
      logic [2:0]      trans_cnt;
      logic            brk_prev;
      logic            side_high;
      logic            pwm_prev;
      logic            fw_active;
      hcb_brake_mode_t brk_mode;
      logic            ocp_en;
      logic            wdt_en;
      logic [7:0]      deadtime_rising;
      logic [7:0]      deadtime_falling;
      logic [7:0]      slew_req;
      logic [7:0]      slew_app;
      logic            ack;
      logic [31:0]     dat;
   } hcb_st_t;

   hcb_st_t    st_r;
   hcb_st_t    st_nxt;
   logic       code_ok;
   logic       trans;
   logic       brk_act;
   logic       brk_evt;
   logic       side_now;
   logic [2:0] pos;
   logic [2:0] mod_ph;
   logic [2:0] on_ph;
   logic [2:0] h_req;
   logic [2:0] l_req;
   logic [2:0] h_gate;
   logic [2:0] l_gate;
   logic [3:0] state_idx;
   logic       wb_req;
   logic [31:0] rd_word;
   logic [31:0] ctrl_word;
   logic [31:0] dt_word;

   // ***********************************************
   // helpers
   // ***********************************************

   // position in one rotation of the direction-1 sequence
   function automatic logic [2:0] hall_pos(input logic [2:0] code);
      logic [2:0] p;
      p = 3'h0;
      case (code)
         3'b101: p = 3'h0;
         3'b100: p = 3'h1;
         3'b110: p = 3'h2;
         3'b010: p = 3'h3;
         3'b011: p = 3'h4;
         3'b001: p = 3'h5;
         default: p = 3'h0;
      endcase
      return p;
   endfunction

   // direction-1 table: modulated phase and fully-on phase, bit0 is phase a
   function automatic logic [5:0] dir1_phases(input logic [2:0] p);
      logic [5:0] r;
      r = 6'h00;
      case (p)
         3'h0: r = {3'b001, 3'b100};
         3'h1: r = {3'b010, 3'b100};
         3'h2: r = {3'b010, 3'b001};
         3'h3: r = {3'b100, 3'b001};
         3'h4: r = {3'b100, 3'b010};
         3'h5: r = {3'b001, 3'b010};
         default: r = 6'h00;
      endcase
      return r;
   endfunction

   // byte-lane merge for writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  sel);
      logic [31:0] m;
      m = old_w;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
            m[8*i +: 8] = new_w[8*i +: 8];
      end
      return m;
   endfunction

   // ***********************************************
   // decode of inputs
   // ***********************************************

   // only the second stage is looked at, the first may be metastable
   assign code_ok = (st_r.hall_s2 != HALL_ALL_LO) && (st_r.hall_s2 != HALL_ALL_HI);
   assign trans   = code_ok && (st_r.hall_s2 != st_r.hall_last);
   assign brk_act = ~st_r.brk_s2
                  | (overcurrent_fault & st_r.ocp_en)
                  | (watchdog_fault & st_r.wdt_en);
   assign brk_evt = brk_act & ~st_r.brk_prev;
   assign pos     = hall_pos(st_r.hall_s2);

   // side while braking; fixed modes follow the field so a run-time rewrite
   // takes hold at once, alternate flips only at a new event
   always_comb
   begin
      side_now = st_r.side_high;
      if (brk_act)
      begin
         case (st_r.brk_mode)
            HCB_BRK_LOW:  side_now = 1'b0;
            HCB_BRK_HIGH: side_now = 1'b1;
            HCB_BRK_ALT:  side_now = brk_evt ? ~st_r.side_high : st_r.side_high;
            default:      side_now = st_r.side_high;
         endcase
      end
   end

   // direction 0 swaps the roles of the two phases
   always_comb
   begin
      if (direction_in)
         {mod_ph, on_ph} = dir1_phases(pos);
      else
         {on_ph, mod_ph} = dir1_phases(pos);
   end

   // ***********************************************
   // gate requests
   // ***********************************************

   // brake first, then invalid code, then the commutation halves;
   // diode freewheeling simply drops the complement term
   always_comb
   begin
      h_req = 3'b000;
      l_req = 3'b000;
      if (brk_act)
      begin
         case (st_r.brk_mode)
            HCB_BRK_HIZ: ;
            default:
            begin
               h_req = {3{side_now}};
               l_req = {3{~side_now}};
            end
         endcase
      end
      else if (!code_ok)
      begin
         h_req = 3'b000;
         l_req = 3'b000;
      end
      else
      begin
         case (st_r.half)
            HCB_HALF_LS_ON:
            begin
               h_req = mod_ph & {3{pwm_in}};
               l_req = on_ph | (mod_ph & {3{~pwm_in & st_r.fw_active}});
            end
            HCB_HALF_HS_ON:
            begin
               h_req = mod_ph | (on_ph & {3{~pwm_in & st_r.fw_active}});
               l_req = on_ph & {3{pwm_in}};
            end
            default:
            begin
               h_req = 3'b000;
               l_req = 3'b000;
            end
         endcase
      end
   end

   // ***********************************************
   // per-phase dead-time insertion
   // ***********************************************

   // a brake pattern that conflicts drops the old gate at once, then waits
   for (genvar ph = 0; ph < 3; ph++)
   begin : g_phase
      hcb_deadtime u_dt
      (
         .ref_clk   (ref_clk),
         .rst_n     (rst_n),
         .h_req     (h_req[ph]),
         .l_req     (l_req[ph]),
         .deadtime_rising   (st_r.deadtime_rising),
         .deadtime_falling   (st_r.deadtime_falling),
         .high_gate (h_gate[ph]),
         .low_gate  (l_gate[ph])
      );
   end

   assign high_gate_a = h_gate[0];
   assign low_gate_a  = l_gate[0];
   assign high_gate_b = h_gate[1];
   assign low_gate_b  = l_gate[1];
   assign high_gate_c = h_gate[2];
   assign low_gate_c  = l_gate[2];

   // ***********************************************
   // register bus
   // ***********************************************
   assign wb_req    = wb_cyc_i & wb_stb_i & ~st_r.ack;
   assign state_idx = (st_r.half == HCB_HALF_HS_ON) ? ({1'b0, pos} + STEPS_PER_HALF)
                                                    : {1'b0, pos};
   assign ctrl_word = {27'h0, st_r.wdt_en, st_r.ocp_en, st_r.brk_mode, st_r.fw_active};
   assign dt_word   = {16'h0, st_r.deadtime_falling, st_r.deadtime_rising};

   // unmapped words read as zero and ignore writes
   always_comb
   begin
      case (wb_adr_i)
         REG_CTRL:     rd_word = ctrl_word;
         REG_DEADTIME: rd_word = dt_word;
         REG_SLEW:     rd_word = {16'h0, st_r.slew_app, st_r.slew_req};
         REG_STATUS:   rd_word = {19'h0, st_r.trans_cnt, direction_in, st_r.side_high,
                                  brk_act, state_idx, st_r.hall_s2};
         default:      rd_word = 32'h0;
      endcase
   end

   // ***********************************************
   // next state
   // ***********************************************
   always_comb
   begin
      logic [31:0] w;
      w = 32'h0;
      st_nxt = st_r;
      // two-stage synchronisers; phase a is the top bit of the hall code
      st_nxt.hall_s1 = {hall_a_in, hall_b_in, hall_c_in};
      st_nxt.hall_s2 = st_r.hall_s1;
      st_nxt.brk_s1  = brake_request_n;
      st_nxt.brk_s2  = st_r.brk_s1;
      st_nxt.brk_prev = brk_act;
      st_nxt.side_high = side_now;
      st_nxt.pwm_prev  = pwm_in;
      // sixth valid transition completes a rotation and swaps halves
      if (trans)
      begin
         st_nxt.hall_last = st_r.hall_s2;
         if (st_r.trans_cnt == STEPS_LAST)
         begin
            st_nxt.trans_cnt = 3'h0;
            case (st_r.half)
               HCB_HALF_LS_ON: st_nxt.half = HCB_HALF_HS_ON;
               HCB_HALF_HS_ON: st_nxt.half = HCB_HALF_LS_ON;
               default:        st_nxt.half = HCB_HALF_LS_ON;
            endcase
         end
         else
            st_nxt.trans_cnt = st_r.trans_cnt + 3'h1;
      end
      // slew takes effect only on a pwm edge, never mid transition
      if (pwm_in != st_r.pwm_prev)
         st_nxt.slew_app = st_r.slew_req;
      // bus access, one wait-free cycle to ack
      st_nxt.ack = wb_req;
      st_nxt.dat = wb_req ? rd_word : 32'h0;
      if (wb_req && wb_we_i)
      begin
         case (wb_adr_i)
            REG_CTRL:
            begin
               w = lane_merge(ctrl_word, wb_dat_i, wb_sel_i);
               st_nxt.fw_active = w[CTRL_FW];
               st_nxt.brk_mode  = hcb_brake_mode_t'(w[CTRL_BRK_LO +: 2]);
               st_nxt.ocp_en    = w[CTRL_OCP_EN];
               st_nxt.wdt_en    = w[CTRL_WDT_EN];
            end
            REG_DEADTIME:
            begin
               w = lane_merge(dt_word, wb_dat_i, wb_sel_i);
               st_nxt.deadtime_rising = w[7:0];
               st_nxt.deadtime_falling = w[15:8];
            end
            REG_SLEW:
            begin
               if (wb_sel_i[0])
                  st_nxt.slew_req = wb_dat_i[7:0];
            end
            default: ;
         endcase
      end
   end

   // ***********************************************
   // state register
   // ***********************************************
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r           <= '0;
         st_r.hall_s1   <= HALL_ALL_LO;
         st_r.brk_s1    <= 1'b1;
         st_r.brk_s2    <= 1'b1;
         st_r.half      <= HCB_HALF_LS_ON;
         st_r.fw_active <= RST_FW_ACTIVE;
         st_r.brk_mode  <= HCB_BRK_LOW;
         st_r.deadtime_rising   <= RST_DEADTIME_RISING;
         st_r.deadtime_falling   <= RST_DEADTIME_FALLING;
         st_r.slew_req  <= RST_SLEW;
         st_r.slew_app  <= RST_SLEW;
      end
      else
         st_r <= st_nxt;
   end

   assign wb_ack_o  = st_r.ack;
   assign wb_dat_o  = st_r.dat;
   assign slew_code = st_r.slew_app;

   // ***********************************************
   // checks
   // ***********************************************
   chk_invalid_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!brk_act && !code_ok) |-> (h_req == 3'b000 && l_req == 3'b000))
      else $error("invalid hall code drives a gate");

   chk_diode_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!st_r.fw_active && !brk_act) |-> ($onehot0(l_req) && $onehot0(h_req)))
      else $error("diode freewheel drives a complement gate");

   chk_brake_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (brk_act && st_r.brk_mode == HCB_BRK_LOW) |-> (l_req == 3'b111 && h_req == 3'b000))
      else $error("low-side brake pattern wrong");

   chk_brake_hiz: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (brk_act && st_r.brk_mode == HCB_BRK_HIZ) |-> ##1 (h_gate == 3'b000 && l_gate == 3'b000))
      else $error("non-power brake left a gate on");

   chk_alt_toggle: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (brk_evt && st_r.brk_mode == HCB_BRK_ALT) |=> (st_r.side_high != $past(st_r.side_high)))
      else $error("alternate brake did not change side");

   chk_half_swap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (trans && st_r.trans_cnt == STEPS_LAST) |=> (st_r.half != $past(st_r.half)))
      else $error("halves not swapped after six transitions");

   chk_slew_sync: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $changed(st_r.slew_app) |-> ($past(pwm_in) != $past(st_r.pwm_prev)))
      else $error("slew changed away from a pwm edge");

   chk_wb_ack: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (wb_cyc_i && wb_stb_i && !st_r.ack) |=> st_r.ack ##1 !st_r.ack)
      else $error("bus ack not one cycle");

endmodule
`default_nettype wire

// File: test/hcb_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// controller model
// ****
module hcb_mcu_model
(
   // clock
   input  wire logic ref_clk,
   // commands from the bench
   input  wire logic pwm_cmd,
   input  wire logic dir_cmd,
   input  wire logic brake_cmd,
   // pins into the block
   output logic      pwm_in,
   output logic      direction_in,
   output logic      brake_request_n
);
   // quiet pins before the first edge
   initial
   begin
      pwm_in          = 1'b0;
      direction_in    = 1'b1;
      brake_request_n = 1'b1;
   end
   // port register: pins move only just after an edge, as a real timer output
   always @(posedge ref_clk)
   begin
      pwm_in          <= pwm_cmd;
      direction_in    <= dir_cmd;
      brake_request_n <= ~brake_cmd;
   end
endmodule
`default_nettype wire

// File: test/hall_commutation_brake_deadtime_test.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module hall_commutation_brake_deadtime_test;
   import hcb_pkg::*;
   logic        ref_clk, rst_n, cyc, stb, we;
   logic [7:0]  adr;
   logic [31:0] wdat;
   logic        pwm_c, dir_c, brk_c, ocf, wdf;
   logic [2:0]  hall;
   wire         ack, pwm, dir, brk_n;
   wire  [31:0] rdat;
   wire  [7:0]  slew;
   wire  [5:0]  g;
   int          errors, num_checks, cycles;

   hcb_mcu_model u_mcu (.ref_clk(ref_clk), .pwm_cmd(pwm_c), .dir_cmd(dir_c),
      .brake_cmd(brk_c), .pwm_in(pwm), .direction_in(dir), .brake_request_n(brk_n));

   hcb_commutator dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .pwm_in(pwm), .direction_in(dir), .brake_request_n(brk_n),
      .hall_a_in(hall[2]), .hall_b_in(hall[1]), .hall_c_in(hall[0]),
      .overcurrent_fault(ocf), .watchdog_fault(wdf), .high_gate_a(g[5]), .low_gate_a(g[4]),
      .high_gate_b(g[3]), .low_gate_b(g[2]), .high_gate_c(g[1]), .low_gate_c(g[0]),
      .slew_code(slew));

   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // classic cycle; waits for ack however long it takes, timeout cuts a hang
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      @(posedge ref_clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do @(posedge ref_clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      cmp32(q, exp);
   endtask

   // gates settle through sync and dead time, so wait a bounded while
   task automatic gates(input logic [5:0] exp);
      int n;
      n = 0;
      while (g !== exp && n < 80)
      begin
         @(negedge ref_clk);
         n++;
      end
      cmp32({26'h0, g}, {26'h0, exp});
   endtask

   task automatic t_regs;
      rd(REG_CTRL, {31'h0, RST_FW_ACTIVE});
      rd(REG_DEADTIME, {16'h0, RST_DEADTIME_FALLING, RST_DEADTIME_RISING});
      rd(8'h10, 32'h0);
      wr(REG_DEADTIME, 32'h0606);
      rd(REG_DEADTIME, 32'h0606);
   endtask

   task automatic t_slew;
      int n;
      wr(REG_SLEW, 32'h33);
      rd(REG_SLEW, 32'h33);
      cmp32({24'h0, slew}, {24'h0, RST_SLEW});
      @(posedge ref_clk) pwm_c <= 1'b1;
      for (n = 0; n < 40 && slew !== 8'h33; n++) @(negedge ref_clk);
      cmp32({24'h0, slew}, 32'h33);
      @(posedge ref_clk) pwm_c <= 1'b0;
      rd(REG_SLEW, 32'h3333);
   endtask

   task automatic t_commute;
      logic [2:0] seq [6] = '{3'b101, 3'b100, 3'b110, 3'b010, 3'b011, 3'b001};
      logic [5:0] lo0 [6] = '{6'h11, 6'h05, 6'h14, 6'h11, 6'h05, 6'h28};
      @(posedge ref_clk) hall <= 3'b101;
      gates(6'b010001);
      @(posedge ref_clk) pwm_c <= 1'b1;
      gates(6'b100001);
      wr(REG_CTRL, 32'h0);
      @(posedge ref_clk) pwm_c <= 1'b0;
      gates(6'b000001);
      @(posedge ref_clk) dir_c <= 1'b0;
      pwm_c <= 1'b1;
      gates(6'b010010);
      wr(REG_CTRL, 32'h1);
      @(posedge ref_clk) dir_c <= 1'b1;
      pwm_c <= 1'b0;
      gates(6'b010001);
      for (int i = 1; i < 6; i++)
      begin
         @(posedge ref_clk) hall <= seq[i];
         gates(lo0[i]);
      end
      @(posedge ref_clk) hall <= 3'b101;
      gates(6'b100010);
      wr(REG_CTRL, 32'h0);
      gates(6'b100000);
      wr(REG_CTRL, 32'h1);
      @(posedge ref_clk) dir_c <= 1'b0;
      pwm_c <= 1'b1;
      gates(6'b010010);
      @(posedge ref_clk) dir_c <= 1'b1;
      pwm_c <= 1'b0;
      gates(6'b100010);
   endtask

   // brake level toggles; each rise is a fresh braking event
   task automatic brake(input logic [31:0] ctrl, input logic [5:0] exp, input logic [5:0] rel);
      wr(REG_CTRL, ctrl);
      @(posedge ref_clk) brk_c <= 1'b1;
      gates(exp);
      @(posedge ref_clk) brk_c <= 1'b0;
      gates(rel);
   endtask

   task automatic t_brake;
      brake(32'h7, 6'b000000, 6'b100010);
      @(posedge ref_clk) brk_c <= 1'b1;
      wr(REG_CTRL, 32'h1);
      gates(6'b010101);
      @(posedge ref_clk) brk_c <= 1'b0;
      hall <= 3'b000;
      gates(6'b000000);
      brake(32'h3, 6'b101010, 6'b000000);
      brake(32'h5, 6'b010101, 6'b000000);
      brake(32'h5, 6'b101010, 6'b000000);
      wr(REG_CTRL, 32'h9);
      @(posedge ref_clk) ocf <= 1'b1;
      gates(6'b010101);
      @(posedge ref_clk) ocf <= 1'b0;
      gates(6'b000000);
      wr(REG_CTRL, 32'h11);
      @(posedge ref_clk) wdf <= 1'b1;
      gates(6'b010101);
      wr(REG_CTRL, 32'h13);
      gates(6'b101010);
      @(posedge ref_clk) wdf <= 1'b0;
      gates(6'b000000);
   endtask

   task end_sim;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // shoot-through watch on every phase, every cycle
   always @(negedge ref_clk)
      if (rst_n === 1'b1)
         cmp32({31'h0, |(g[5:4] == 2'b11) | (g[3:2] == 2'b11) | (g[1:0] == 2'b11)}, 32'h0);

   // generous ceiling: all scenarios need a few hundred cycles
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         end_sim;
      end
   end

   initial
   begin
      {rst_n, cyc, stb, we, pwm_c, brk_c, ocf, wdf} = '0;
      {adr, wdat, hall, errors, num_checks, cycles} = '0;
      dir_c = 1'b1;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_regs;
      t_slew;
      t_commute;
      t_brake;
      end_sim;
   end
endmodule
`default_nettype wire
